// >>> rtl/tdmps_chan_mem.sv
// one-frame channel store with registered read data
`timescale 1ns/1ns
`include "tdmps_consts.svh"
module tdmps_chan_mem
  import tdmps_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // write side
  input wire logic wr_en_i,
  input wire logic [4:0] wr_addr_i,
  input wire tdmps_byte_t wr_data_i,
  // read side
  input wire logic rd_en_i,
  input wire logic [4:0] rd_addr_i,
  output tdmps_byte_t rd_data_o
);
  tdmps_byte_t mem [0:`TDMPS_CHANNELS-1];

  // storage array, no reset
  always_ff @(posedge ref_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // registered read port
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_data_o <= `TDMPS_IDLE_BYTE;
    end else if (rd_en_i) begin
      rd_data_o <= mem[rd_addr_i];
    end
  end
endmodule

// >>> rtl/tdmps_consts.svh
// timing, framing and reset constants of the tdm pcm serial port
`ifndef TDMPS_CONSTS_SVH
`define TDMPS_CONSTS_SVH
// ----------------------------------------------------------------
// framing
// ----------------------------------------------------------------
`define TDMPS_CHANNELS 32
`define TDMPS_CH_W 5
`define TDMPS_FRAME_CNT_W 9
`define TDMPS_FRAME_LAST 9'h1FF
`define TDMPS_PH_SAMPLE_LAST 4'hF
`define TDMPS_PH_LOAD 4'h0
`define TDMPS_PH_FETCH 4'hE
`define TDMPS_PULSE_MAX 3'h2
`define TDMPS_RUN_MAX 3'h7
`define TDMPS_IDLE_BYTE 8'hFF
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TDMPS_REF_CLK_NS 10
`define TDMPS_BCLK_NS 244
`define TDMPS_LOSS_NS (2 * `TDMPS_BCLK_NS)
`define TDMPS_LOSS_CYC ((`TDMPS_LOSS_NS) / (`TDMPS_REF_CLK_NS))
`define TDMPS_WDOG_W 6
`endif

// >>> rtl/tdmps_pkg.sv
// types shared by the tdm pcm serial port
package tdmps_pkg;
  // pins sampled from outside the ref clock domain
  typedef struct packed {
    logic bclk;
    logic fsync;
    logic rin;
    logic sin;
    logic output_drive_enable;
  } tdmps_pins_s;
  // frame alignment states, gray along search-align-locked
  typedef enum logic [1:0] {
    TDMPS_SEARCH = 2'b00,
    TDMPS_ALIGN = 2'b01,
    TDMPS_LOCKED = 2'b11
  } tdmps_lock_e;
  typedef logic [7:0] tdmps_byte_t;
endpackage

// >>> rtl/tdmps_top.sv
// tdm pcm serial port: two input and two output 32-channel streams
// Function
// - both output streams drive only while the enable pin and control bit 6 are high, else both float.
// - every stream carries 2.048 Mb/s with 32 eight-bit timeslots per frame.
// - receive in feeds send out as port 1 and send in feeds receive out as port 2, channel for channel.
// - the frame pulse is accepted in either polarity convention and the one present is found unaided.
// - the far side supplies a 4.096 MHz serial clock that shifts all four streams.
`timescale 1ns/1ns
`include "tdmps_consts.svh"
module tdmps_top
  import tdmps_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // serial link pins
  input wire logic bit_clock_4m_i,
  input wire logic frame_sync_in_i,
  input wire logic recv_in_i,
  input wire logic send_in_i,
  // output drive control
  input wire logic output_drive_enable_i,
  input wire logic ctrl_out_enable_i,
  // serial outputs with enables
  output logic send_out_o,
  output logic send_out_oe_o,
  output logic recv_out_o,
  output logic recv_out_oe_o,
  // status
  output logic frame_gci_o,
  output logic frame_locked_o
);
  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic at_phase(input logic [8:0] cnt, input logic [3:0] ph);
    at_phase = (cnt[3:0] == ph);
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  tdmps_pins_s pins_raw;
  tdmps_pins_s pins_meta;
  tdmps_pins_s pins;
  logic bclk_d;
  logic bclk_rise;

  assign pins_raw = '{bclk: bit_clock_4m_i, fsync: frame_sync_in_i, rin: recv_in_i,
                      sin: send_in_i, output_drive_enable: output_drive_enable_i};

  // two flops for every asynchronous pin
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pins_meta <= '0;
      pins <= '0;
    end else begin
      pins_meta <= pins_raw;
      pins <= pins_meta;
    end
  end

  // serial clock edge finder
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bclk_d <= 1'b0;
    end else begin
      bclk_d <= pins.bclk;
    end
  end
  assign bclk_rise = pins.bclk & ~bclk_d;

  // ----------------------------------------------------------------
  // frame pulse format detection
  // ----------------------------------------------------------------
  logic fs_level;
  logic [2:0] fs_run;
  logic pulse_end;

  // a level that lasts at most two serial clocks is the pulse; its polarity names the format
  assign pulse_end = bclk_rise && (pins.fsync != fs_level) && (fs_run <= `TDMPS_PULSE_MAX);

  // run length of the current frame pulse level, counted in serial clocks
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fs_level <= 1'b1;
      fs_run <= `TDMPS_RUN_MAX;
    end else if (bclk_rise) begin
      if (pins.fsync != fs_level) begin
        fs_level <= pins.fsync;
        fs_run <= 3'h1;
      end else if (fs_run != `TDMPS_RUN_MAX) begin
        fs_run <= fs_run + 3'h1;
      end
    end
  end

  // latch the detected convention: a short high pulse is gci, a short low one the other
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      frame_gci_o <= 1'b0;
    end else if (pulse_end) begin
      frame_gci_o <= fs_level;
    end
  end

  // ----------------------------------------------------------------
  // frame counter and lock
  // ----------------------------------------------------------------
  logic [8:0] cnt;
  logic [8:0] cnt_now;
  logic [4:0] chan;
  logic [5:0] wdog;
  logic clk_lost;
  tdmps_lock_e lock_st;
  tdmps_lock_e next_lock_st;

  // position of the serial clock rise being handled now; the rise that ends the pulse is 0
  assign cnt_now = pulse_end ? 9'h000 : cnt + 9'h001;
  assign chan = cnt_now[8:4];
  assign clk_lost = (wdog == 6'(`TDMPS_LOSS_CYC));

  // 512 serial clocks per frame, restarted by each pulse
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt <= '0;
    end else if (pulse_end) begin
      cnt <= '0;
    end else if (bclk_rise) begin
      cnt <= cnt + 9'h001;
    end
  end

  // serial clock loss watchdog
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wdog <= '0;
    end else if (bclk_rise) begin
      wdog <= '0;
    end else if (!clk_lost) begin
      wdog <= wdog + 6'h01;
    end
  end

  // lock: a pulse found exactly one frame after the last one
  always_comb begin
    next_lock_st = lock_st;
    case (lock_st)
      TDMPS_SEARCH: begin
        if (pulse_end) begin
          next_lock_st = TDMPS_ALIGN;
        end
      end
      TDMPS_ALIGN: begin
        if (pulse_end && cnt == `TDMPS_FRAME_LAST) begin
          next_lock_st = TDMPS_LOCKED;
        end
      end
      TDMPS_LOCKED: begin
        if (pulse_end && cnt != `TDMPS_FRAME_LAST) begin
          next_lock_st = TDMPS_ALIGN;
        end
      end
      default: begin
        next_lock_st = TDMPS_SEARCH;
      end
    endcase
    if (clk_lost) begin
      next_lock_st = TDMPS_SEARCH;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lock_st <= TDMPS_SEARCH;
      frame_locked_o <= 1'b0;
    end else begin
      lock_st <= next_lock_st;
      frame_locked_o <= (next_lock_st == TDMPS_LOCKED);
    end
  end

  // ----------------------------------------------------------------
  // per path shifters and channel stores
  // ----------------------------------------------------------------
  logic [1:0] din;
  logic [1:0] dout;
  logic active;

  assign din = {pins.sin, pins.rin};
  assign active = (lock_st != TDMPS_SEARCH);

  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_path
      tdmps_byte_t in_sr;
      tdmps_byte_t out_sr;
      tdmps_byte_t rd_data;
      logic wr_en;
      logic rd_en;
      logic [4:0] next_chan;

      assign next_chan = chan + 5'h01;
      assign wr_en = bclk_rise && active && at_phase(cnt_now, `TDMPS_PH_SAMPLE_LAST);
      assign rd_en = bclk_rise && at_phase(cnt_now, `TDMPS_PH_FETCH);

      // sample each bit on the second serial clock of its cell, msb first
      always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          in_sr <= `TDMPS_IDLE_BYTE;
        end else if (bclk_rise && cnt_now[0]) begin
          in_sr <= {in_sr[6:0], din[p]};
        end
      end

      // byte of the previous frame loaded at channel start, shifted once per bit
      always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          out_sr <= `TDMPS_IDLE_BYTE;
        end else if (bclk_rise && at_phase(cnt_now, `TDMPS_PH_LOAD)) begin
          out_sr <= active ? rd_data : `TDMPS_IDLE_BYTE;
        end else if (bclk_rise && !cnt_now[0]) begin
          out_sr <= {out_sr[6:0], 1'b1};
        end
      end

      assign dout[p] = out_sr[7];

      tdmps_chan_mem u_mem (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_en_i(wr_en),
        .wr_addr_i(chan),
        .wr_data_i({in_sr[6:0], din[p]}),
        .rd_en_i(rd_en),
        .rd_addr_i(next_chan),
        .rd_data_o(rd_data)
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // output pins
  // ----------------------------------------------------------------
  // port 1 drives send out, port 2 drives receive out; enables need pin and control bit
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      send_out_o <= 1'b1;
      recv_out_o <= 1'b1;
      send_out_oe_o <= 1'b0;
      recv_out_oe_o <= 1'b0;
    end else begin
      send_out_o <= dout[0];
      recv_out_o <= dout[1];
      send_out_oe_o <= pins.output_drive_enable & ctrl_out_enable_i;
      recv_out_oe_o <= pins.output_drive_enable & ctrl_out_enable_i;
    end
  end
endmodule

// >>> tb/tdmps_far_side.sv
// far side of the link: serial clock, frame pulse, channel data and capture
`timescale 1ns/1ns
module tdmps_far_side (
  // format and resolved wires
  input wire logic gci_i,
  input wire logic send_wire_i,
  input wire logic recv_wire_i,
  // clock stop request
  input wire logic hold_i,
  // link pins
  output logic bclk_o,
  output logic fsync_o,
  output logic rin_o,
  output logic sin_o,
  // frames sent
  output int frames_o
);
  logic [8:0] cnt;
  logic [7:0] rb, sb, sh_s, sh_r;
  logic [7:0] so_b [32];
  logic [7:0] ro_b [32];
  // 125 ns clock; pins change on the fall, offset off the ref edges
  initial begin
    bclk_o = 1'b0;
    cnt = 9'h1FF;
    frames_o = 0;
    #4;
    forever begin
      // a held link keeps its clock low
      while (hold_i) #10;
      cnt = cnt + 9'h001;
      if (cnt == 9'h000) frames_o++;
      fsync_o = (cnt == 9'h1FF) ? gci_i : !gci_i;
      rb = {3'h5, cnt[8:4]};
      sb = {3'h2, cnt[8:4]};
      rin_o = rb[3'h7 - cnt[3:1]];
      sin_o = sb[3'h7 - cnt[3:1]];
      #63 bclk_o = 1'b1;
      if (cnt[0]) begin
        sh_s = {sh_s[6:0], send_wire_i};
        sh_r = {sh_r[6:0], recv_wire_i};
      end
      if (cnt[3:0] == 4'hF) begin
        so_b[cnt[8:4]] = sh_s;
        ro_b[cnt[8:4]] = sh_r;
      end
      #62 bclk_o = 1'b0;
    end
  end
endmodule

// >>> tb/tdmps_top_assertions.sv
// concurrent checks on the tdm pcm serial port pins
`timescale 1ns/1ns
module tdmps_top_assertions (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // pins in
  input wire logic bit_clock_4m_i,
  input wire logic frame_sync_in_i,
  input wire logic output_drive_enable_i,
  input wire logic ctrl_out_enable_i,
  // pins out
  input wire logic send_out_o,
  input wire logic send_out_oe_o,
  input wire logic recv_out_o,
  input wire logic recv_out_oe_o,
  input wire logic frame_gci_o,
  input wire logic frame_locked_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // enables need both the synced pin and the control bit
  property p_oe_on; output_drive_enable_i [*4] ##0 ctrl_out_enable_i |=> send_out_oe_o && recv_out_oe_o; endproperty
  a_oe_on: assert property (p_oe_on) else $error("oe not raised");
  property p_ctl_off; !ctrl_out_enable_i |=> !send_out_oe_o && !recv_out_oe_o; endproperty
  a_ctl_off: assert property (p_ctl_off) else $error("oe kept on control low");
  property p_pin_off; !output_drive_enable_i [*4] |=> !send_out_oe_o && !recv_out_oe_o; endproperty
  a_pin_off: assert property (p_pin_off) else $error("oe kept on pin low");
  // data moves only after a serial clock rise; while locked, send out then holds for 8 ref clocks
  property p_on_rise; $changed(send_out_o) || $changed(recv_out_o) |-> $past(bit_clock_4m_i, 2); endproperty
  a_on_rise: assert property (p_on_rise) else $error("data moved without clock rise");
  property p_hold; $changed(send_out_o) && frame_locked_o |=> $stable(send_out_o) [*8]; endproperty
  a_hold: assert property (p_hold) else $error("bit shorter than two clocks");
  // format and lock settle when the pulse returns to idle
  property p_fmt; $changed(frame_gci_o) |-> frame_gci_o != frame_sync_in_i; endproperty
  a_fmt: assert property (p_fmt) else $error("format taken off the idle level");
  property p_lock; $rose(frame_locked_o) |-> frame_gci_o != frame_sync_in_i; endproperty
  a_lock: assert property (p_lock) else $error("lock outside frame start");
  c_lock: cover property ($rose(frame_locked_o));
  c_gci: cover property ($rose(frame_gci_o));
  c_oe: cover property ($rose(send_out_oe_o));
  c_unlock: cover property ($fell(frame_locked_o));
endmodule
bind tdmps_top tdmps_top_assertions u_chk (.ref_clk_i, .sys_rst_i, .bit_clock_4m_i, .frame_sync_in_i,
  .output_drive_enable_i, .ctrl_out_enable_i, .send_out_o, .send_out_oe_o, .recv_out_o, .recv_out_oe_o,
  .frame_gci_o, .frame_locked_o);

// >>> tb/tdmps_top_tb.sv
// self-checking bench of the tdm pcm serial port
`timescale 1ns/1ns
module tdmps_top_tb;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic drv_en = 1'b0;
  logic ctrl_en = 1'b0;
  logic gci = 1'b1;
  logic hold = 1'b0;
  logic bclk, fsync, rin, sin, sout, soe, rout, roe, fgci, flock;
  wire s_w, r_w;
  int frames;
  int num_errors = 0;
  int compares = 0;
  // 100 MHz clock
  always #5 ref_clk_i = ~ref_clk_i;
  // wires float while the enables are low
  assign s_w = soe ? sout : 1'bZ;
  assign r_w = roe ? rout : 1'bZ;
  tdmps_top dut (.ref_clk_i, .sys_rst_i, .bit_clock_4m_i(bclk), .frame_sync_in_i(fsync), .recv_in_i(rin),
    .send_in_i(sin), .output_drive_enable_i(drv_en), .ctrl_out_enable_i(ctrl_en), .send_out_o(sout),
    .send_out_oe_o(soe), .recv_out_o(rout), .recv_out_oe_o(roe), .frame_gci_o(fgci), .frame_locked_o(flock));
  tdmps_far_side u_far (.gci_i(gci), .send_wire_i(s_w), .recv_wire_i(r_w), .hold_i(hold), .bclk_o(bclk), .fsync_o(fsync),
    .rin_o(rin), .sin_o(sin), .frames_o(frames));
  // compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // counts, verdict, end
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // reset for 10 cycles with a chosen pulse format
  task automatic do_reset(input logic g);
    @(posedge ref_clk_i);
    #1 sys_rst_i = 1'b1;
    gci = g;
    repeat (10) @(posedge ref_clk_i);
    #1 sys_rst_i = 1'b0;
  endtask
  // bounded wait for n far side frames
  task automatic wait_frames(input int n);
    int goal;
    goal = frames + n;
    for (int i = 0; i < 7000 * n && frames < goal; i++) @(posedge ref_clk_i);
    if (frames < goal) begin
      num_errors++;
      stop_test();
    end
  endtask
  // every enable pair; only both high drives
  task automatic t_oe;
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk_i);
      #1 {drv_en, ctrl_en} = i[1:0];
      repeat (5) @(posedge ref_clk_i);
      #1 check("send oe", {7'h00, soe}, {7'h00, i == 3});
      check("recv oe", {7'h00, roe}, {7'h00, i == 3});
    end
    $display("t_oe done");
  endtask
  // lock, format and channel loopback of both ports
  task automatic t_stream(input logic g);
    do_reset(g);
    wait_frames(4);
    check("locked", {7'h00, flock}, 8'h01);
    check("format", {7'h00, fgci}, {7'h00, g});
    for (int ch = 0; ch < 32; ch++) begin
      check("send out", u_far.so_b[ch], {3'h5, ch[4:0]});
      check("recv out", u_far.ro_b[ch], {3'h2, ch[4:0]});
    end
    $display("t_stream done");
  endtask
  // serial clock stopped for 1 us: lock must drop
  task automatic t_loss;
    @(posedge ref_clk_i);
    #1 hold = 1'b1;
    repeat (100) @(posedge ref_clk_i);
    #1 check("lock lost", {7'h00, flock}, 8'h00);
    hold = 1'b0;
    $display("t_loss done");
  endtask
  // main sequence
  initial begin
    do_reset(1'b1);
    t_oe();
    t_stream(1'b1);
    t_loss();
    t_stream(1'b0);
    stop_test();
  end
endmodule
